// >>> hdl/data_mem.sv
// Purpose: data-memory array of the execution unit
// Assumes: one write port, one read port, same clock
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/100ps
module data_mem (
    input wire logic sys_clk,
    input wire logic [exec_unit_pkg::ADDR_W-1:0] raddr,
    output logic [exec_unit_pkg::DATA_W-1:0] rdata,
    input wire logic wen,
    input wire logic [exec_unit_pkg::ADDR_W-1:0] waddr,
    input wire logic [exec_unit_pkg::DATA_W-1:0] wdata
);
    import exec_unit_pkg::*;

    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // no reset on the array, contents are undefined until written
    always_ff @(posedge sys_clk) begin
        if (wen) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge sys_clk) begin
        rdata <= mem[raddr];
    end
endmodule

// >>> hdl/exec_unit.sv
// Purpose: rotate, literal subtract and sleep execution with AHB-Lite regs
// Assumes: single AHB-Lite master, word transfers only, zero wait states
// Notes: commands are refused while busy or asleep; status shows both
`timescale 1ns/100ps
module exec_unit (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic osc_enable,
    output logic exec_halted
);
    import exec_unit_pkg::*;

    // word offset of a bus address, shared by read and write decode
    function automatic logic [7:0] reg_ofs(input logic [31:0] a);
        reg_ofs = {a[7:2], 2'b00};
    endfunction

    // true when the upper address bits are set or the offset lies past WAKE_OFS
    function automatic logic unmapped(input logic [31:0] a);
        unmapped = (a[31:8] != 24'h000000) || (reg_ofs(a) > WAKE_OFS);
    endfunction

    exec_state_type state_reg;
    exec_state_type state_next;
    op_type op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic dest_reg;
    logic [DATA_W-1:0] lit_reg;
    logic [DATA_W-1:0] acc_reg;
    logic link_reg;
    logic nibble_link_bit;
    logic zero_reg;
    logic timeout_flag;
    logic power_down_flag;
    logic [DATA_W-1:0] memdata_reg;
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [DATA_W-1:0] mem_rdata;
    logic [7:0] wdt_count;
    logic addr_phase;
    logic cmd_accept;
    logic wake_req;
    logic acc_sw_write;
    logic status_sw_write;
    logic wdt_clear;
    logic mem_wen;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] rot_result;
    logic rot_link;
    logic [DATA_W-1:0] sub_result;
    logic sub_link;
    logic sub_nibble;
    logic is_rotate;
    logic in_exec;
    logic [31:0] status_word;
    logic [31:0] read_word;

    assign addr_phase = hsel && htrans[1] && hready;
    assign in_exec = (state_reg == S_EXEC);

    // register writes land in the data phase of the transfer
    assign cmd_accept = wr_pend_reg && wr_ofs_reg == CMD_OFS &&
        state_reg == S_IDLE;
    assign wake_req = wr_pend_reg && wr_ofs_reg == WAKE_OFS &&
        hwdata[0] && state_reg == S_SLEEP;
    assign acc_sw_write = wr_pend_reg && wr_ofs_reg == ACC_OFS;
    assign status_sw_write = wr_pend_reg && wr_ofs_reg == STATUS_OFS;

    // bus slave: always ready, always okay
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // remember a write address phase for the following data phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite && !unmapped(haddr);
            wr_ofs_reg <= reg_ofs(haddr);
        end
    end

    // status word assembled from the live flags
    always_comb begin
        status_word = 32'h00000000;
        status_word[ST_LINK_BIT] = link_reg;
        status_word[ST_NIBBLE_BIT] = nibble_link_bit;
        status_word[ST_ZERO_BIT] = zero_reg;
        status_word[ST_TIMEOUT_BIT] = timeout_flag;
        status_word[ST_PDOWN_BIT] = power_down_flag;
        status_word[ST_SLEEP_BIT] = (state_reg == S_SLEEP);
        status_word[ST_BUSY_BIT] = (state_reg == S_READ) || in_exec;
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        case (reg_ofs(haddr))
            CMD_OFS: read_word = {8'h00, lit_reg, dest_reg, addr_reg,
                5'h00, op_reg};
            ACC_OFS: read_word = {24'h000000, acc_reg};
            STATUS_OFS: read_word = status_word;
            MEMDATA_OFS: read_word = {24'h000000, memdata_reg};
            WDT_OFS: read_word = {24'h000000, wdt_count};
            default: read_word = 32'h00000000;
        endcase
        if (unmapped(haddr)) begin
            read_word = 32'h00000000;
        end
    end

    // read data registered at the address phase, valid in the data phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= read_word;
        end
    end

    // latch the command fields when a command is taken
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_reg <= OP_NONE;
            addr_reg <= '0;
            dest_reg <= 1'b0;
            lit_reg <= 8'h00;
        end else if (cmd_accept) begin
            op_reg <= op_type'(hwdata[CMD_OP_LSB +: 3]);
            addr_reg <= hwdata[CMD_ADDR_LSB +: ADDR_W];
            dest_reg <= hwdata[CMD_DEST_BIT];
            lit_reg <= hwdata[CMD_LIT_LSB +: DATA_W];
        end
    end

    // sequencer: read operand, execute, or park asleep
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (cmd_accept) begin
                    state_next = S_READ;
                end
            end
            S_READ: state_next = S_EXEC;
            S_EXEC: begin
                if (op_reg == OP_SLEEP) begin
                    state_next = S_SLEEP;
                end else begin
                    state_next = S_IDLE;
                end
            end
            S_SLEEP: begin
                if (wake_req) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // rotate through the link bit
    assign is_rotate = (op_reg == OP_ROTATE_LEFT) ||
        (op_reg == OP_ROTATE_RIGHT);
    always_comb begin
        if (op_reg == OP_ROTATE_LEFT) begin
            rot_result = {mem_rdata[6:0], link_reg};
            rot_link = mem_rdata[7];
        end else begin
            rot_result = {link_reg, mem_rdata[7:1]};
            rot_link = mem_rdata[0];
        end
    end

    // literal minus accumulator, borrow shown as inverted link
    assign sub_result = lit_reg - acc_reg;
    assign sub_link = (acc_reg <= lit_reg);
    assign sub_nibble = (acc_reg[3:0] <= lit_reg[3:0]);

    // memory write port: rotate with dest 1, or software load
    always_comb begin
        mem_wen = 1'b0;
        mem_wdata = lit_reg;
        if (in_exec && is_rotate && dest_reg) begin
            mem_wen = 1'b1;
            mem_wdata = rot_result;
        end else if (in_exec && op_reg == OP_MEM_WRITE) begin
            mem_wen = 1'b1;
        end
    end

    // accumulator: execution wins over a software write in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= ACC_RESET;
        end else if (in_exec && is_rotate && !dest_reg) begin
            acc_reg <= rot_result;
        end else if (in_exec && op_reg == OP_LIT_MINUS_ACC) begin
            acc_reg <= sub_result;
        end else if (acc_sw_write) begin
            acc_reg <= hwdata[DATA_W-1:0];
        end
    end

    // link bit: both rotates and the subtract set it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_reg <= 1'b0;
        end else if (in_exec && is_rotate) begin
            link_reg <= rot_link;
        end else if (in_exec && op_reg == OP_LIT_MINUS_ACC) begin
            link_reg <= sub_link;
        end else if (status_sw_write) begin
            link_reg <= hwdata[ST_LINK_BIT];
        end
    end

    // nibble link and zero change only on the subtract or a software status write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nibble_link_bit <= 1'b0;
            zero_reg <= 1'b0;
        end else if (in_exec && op_reg == OP_LIT_MINUS_ACC) begin
            nibble_link_bit <= sub_nibble;
            zero_reg <= (sub_result == 8'h00);
        end else if (status_sw_write) begin
            nibble_link_bit <= hwdata[ST_NIBBLE_BIT];
            zero_reg <= hwdata[ST_ZERO_BIT];
        end
    end

    // sleep status bits, software cannot write them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timeout_flag <= TIMEOUT_RESET;
            power_down_flag <= PDOWN_RESET;
        end else if (in_exec && op_reg == OP_SLEEP) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b0;
        end
    end

    // oscillator stops while asleep; halted mirrors the sleep state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_enable <= 1'b1;
            exec_halted <= 1'b0;
        end else begin
            osc_enable <= (state_next != S_SLEEP);
            exec_halted <= (state_next == S_SLEEP);
        end
    end

    // captured operand for software memory reads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            memdata_reg <= 8'h00;
        end else if (in_exec && op_reg == OP_MEM_READ) begin
            memdata_reg <= mem_rdata;
        end
    end

    assign wdt_clear = in_exec && (op_reg == OP_SLEEP);

    data_mem u_mem (
        .sys_clk(sys_clk),
        .raddr(addr_reg),
        .rdata(mem_rdata),
        .wen(mem_wen),
        .waddr(addr_reg),
        .wdata(mem_wdata)
    );

    // watchdog only advances while the oscillator runs
    watchdog_count u_wdt (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(osc_enable),
        .clear(wdt_clear),
        .count(wdt_count)
    );

    // hsize unused: only whole-word transfers are supported
endmodule

// >>> hdl/watchdog_count.sv
// Purpose: watchdog prescaler and counter
// Assumes: run is low while the oscillator is stopped
// Notes: clear wins over counting in the same cycle
`timescale 1ns/100ps
module watchdog_count (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic clear,
    output logic [7:0] count
);
    import exec_unit_pkg::*;

    logic [7:0] prescale_reg;

    // prescaler wraps once per counter step
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prescale_reg <= PRESCALE_RESET;
        end else if (clear) begin
            prescale_reg <= PRESCALE_RESET;
        end else if (run) begin
            prescale_reg <= prescale_reg + 8'h01;
        end
    end

    // counter steps on prescaler wrap
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= WDT_RESET;
        end else if (clear) begin
            count <= WDT_RESET;
        end else if (run && prescale_reg == 8'hff) begin
            count <= count + 8'h01;
        end
    end
endmodule

// >>> pkg/exec_unit_pkg.sv
// Purpose: constants and types shared by the execution unit files
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: command word layout and register offsets live here
package exec_unit_pkg;

    // register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ACC_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] MEMDATA_OFS = 8'h0c;
    localparam logic [7:0] WDT_OFS = 8'h10;
    localparam logic [7:0] WAKE_OFS = 8'h14;

    // command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DEST_BIT = 15;
    localparam int CMD_LIT_LSB = 16;

    // status word fields
    localparam int ST_LINK_BIT = 0;
    localparam int ST_NIBBLE_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_TIMEOUT_BIT = 3;
    localparam int ST_PDOWN_BIT = 4;
    localparam int ST_SLEEP_BIT = 5;
    localparam int ST_BUSY_BIT = 6;

    // values after reset
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic TIMEOUT_RESET = 1'b1;
    localparam logic PDOWN_RESET = 1'b1;
    localparam logic [7:0] WDT_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int MEM_DEPTH = 128;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ROTATE_LEFT = 3'h1,
        OP_ROTATE_RIGHT = 3'h2,
        OP_LIT_MINUS_ACC = 3'h3,
        OP_SLEEP = 3'h4,
        OP_MEM_WRITE = 3'h5,
        OP_MEM_READ = 3'h6
    } op_type;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_READ = 4'b0010,
        S_EXEC = 4'b0100,
        S_SLEEP = 4'b1000
    } exec_state_type;

endpackage

// >>> tb/exec_unit_monitor.sv
// Purpose: port checker for the execution unit
// Assumes: bench waits for busy to clear before each command
// Notes: sees only the top-level ports
`timescale 1ns/100ps
module exec_unit_monitor
    import exec_unit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic osc_enable,
    input wire logic exec_halted
);
    logic take;
    logic cmd_wr_reg;
    logic wake_wr_reg;
    logic [3:0] since_sleep_reg;
    logic [3:0] since_wake_reg;

    // address phase accepted this edge
    assign take = hsel && htrans[1] && hready;

    // remember which write is now in its data phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_wr_reg <= 1'b0;
            wake_wr_reg <= 1'b0;
        end else begin
            cmd_wr_reg <= take && hwrite && haddr == {24'h0, CMD_OFS};
            wake_wr_reg <= take && hwrite && haddr == {24'h0, WAKE_OFS};
        end
    end

    // saturating ages, so halt edges can be traced to their cause
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since_sleep_reg <= 4'hf;
            since_wake_reg <= 4'hf;
        end else begin
            since_sleep_reg <= (cmd_wr_reg && hwdata[2:0] == 3'h4) ? 4'h0 :
                since_sleep_reg + 4'(since_sleep_reg != 4'hf);
            since_wake_reg <= (wake_wr_reg && hwdata[0]) ? 4'h0 :
                since_wake_reg + 4'(since_wake_reg != 4'hf);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence sleep_req;
        cmd_wr_reg && hwdata[2:0] == 3'h4 && !exec_halted;
    endsequence
    sequence rd_at(logic [7:0] ofs);
        take && !hwrite && haddr == {24'h0, ofs};
    endsequence

    a_osc_vs_halt: assert property (osc_enable == !exec_halted)
        else $error("oscillator and halt disagree");
    a_sleep_halts: assert property (sleep_req |-> ##[1:4] exec_halted)
        else $error("sleep did not halt");
    a_halt_cause: assert property ($rose(exec_halted) |-> since_sleep_reg < 4'h5)
        else $error("halt without sleep");
    a_wake_cause: assert property ($fell(exec_halted) |-> since_wake_reg < 4'h5)
        else $error("left sleep without wake");
    a_sleep_flags: assert property (rd_at(STATUS_OFS) ##0 exec_halted |=> hrdata[4:3] == 2'b01)
        else $error("flags wrong while asleep");
    a_wdt_frozen: assert property (rd_at(WDT_OFS) ##0 exec_halted |=> hrdata == 32'h0)
        else $error("watchdog not clear while asleep");
    a_acc_width: assert property (rd_at(ACC_OFS) |=> hrdata[31:8] == 24'h0)
        else $error("accumulator wider than a byte");
    a_mem_width: assert property (rd_at(MEMDATA_OFS) |=> hrdata[31:8] == 24'h0)
        else $error("memory data wider than a byte");
endmodule

bind exec_unit exec_unit_monitor mon (.sys_clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .osc_enable, .exec_halted);

// >>> tb/test_rotate_subtract_sleep_exec.sv
// Purpose: self-checking bench for the execution unit
// Assumes: zero wait states, command done once busy clears
// Notes: watchdog steps every 256 cycles while running
`timescale 1ns/100ps
module test_rotate_subtract_sleep_exec;
    import exec_unit_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, osc_enable, exec_halted;
    logic [31:0] hrdata;
    int failures = 0;
    int checks_done = 0;

    exec_unit DUT (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .osc_enable,
        .exec_halted);
    assign hready = hreadyout;

    // bench clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // single word transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [31:0] a, wd,
                        output logic [31:0] rdat);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, {24'h0, a}, d, unused);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, {24'h0, a}, 32'h0, d);
    endtask

    // issue a command, then poll busy so the next one is not refused
    task automatic cmd(input logic [2:0] op, input logic [6:0] a,
                       input logic d, input logic [7:0] lit);
        logic [31:0] st;
        wr_reg(CMD_OFS, {8'h0, lit, d, a, 5'h0, op});
        for (int n = 0; n < 20; n++) begin
            rd_reg(STATUS_OFS, st);
            if (st[ST_BUSY_BIT] === 1'b0) break;
        end
    endtask

    task automatic t_reset();
        logic [31:0] v;
        rd_reg(STATUS_OFS, v);
        check("status reset", {27'h0, v[4:0]}, 32'h18);
        rd_reg(ACC_OFS, v);
        check("acc reset", v, 32'h0);
        xfer(1'b0, 32'h100, 32'h0, v);
        check("unmapped", v, 32'h0);
    endtask

    // both rotates, both ends of memory, both destinations and links
    task automatic t_rotate();
        logic [31:0] v;
        logic [7:0] val, res;
        logic [6:0] a;
        logic lnk;
        for (int i = 0; i < 8; i++) begin
            lnk = i[0];
            a = i[1] ? 7'h7f : 7'h00;
            val = {!lnk, 6'h2b, !lnk};
            res = i[2] ? {lnk, val[7:1]} : {val[6:0], lnk};
            cmd(3'h5, a, 1'b0, val);
            wr_reg(ACC_OFS, 32'h5a);
            wr_reg(STATUS_OFS, {29'h0, 2'b11, lnk});
            cmd(i[2] ? 3'h2 : 3'h1, a, i[1], 8'h0);
            rd_reg(STATUS_OFS, v);
            check("rot flags", {29'h0, v[2:0]}, {29'h0, 2'b11, !lnk});
            rd_reg(ACC_OFS, v);
            check("rot acc", v, {24'h0, i[1] ? 8'h5a : res});
            cmd(3'h6, a, 1'b0, 8'h0);
            rd_reg(MEMDATA_OFS, v);
            check("rot mem", v, {24'h0, i[1] ? res : val});
        end
    endtask

    // equal, borrow, nibble borrow only, extremes; dest bit set throughout
    task automatic t_sub();
        logic [7:0] acc_t[5] = '{8'h05, 8'h06, 8'h0f, 8'h00, 8'hff};
        logic [7:0] lit_t[5] = '{8'h05, 8'h05, 8'h10, 8'hff, 8'h00};
        logic [31:0] v, e;
        logic [7:0] r;
        cmd(3'h5, 7'h03, 1'b0, 8'h33);
        for (int i = 0; i < 5; i++) begin
            r = lit_t[i] - acc_t[i];
            e = {29'h0, r == 8'h0, acc_t[i][3:0] <= lit_t[i][3:0],
                 acc_t[i] <= lit_t[i]};
            wr_reg(ACC_OFS, {24'h0, acc_t[i]});
            cmd(3'h3, 7'h03, 1'b1, lit_t[i]);
            rd_reg(ACC_OFS, v);
            check("sub acc", v, {24'h0, r});
            rd_reg(STATUS_OFS, v);
            check("sub flags", {29'h0, v[2:0]}, e);
        end
        cmd(3'h6, 7'h03, 1'b0, 8'h0);
        rd_reg(MEMDATA_OFS, v);
        check("sub mem", v, 32'h33);
    endtask

    // sleep with a running watchdog, refused command, then wake
    task automatic t_sleep();
        logic [31:0] v;
        repeat (600) @(posedge sys_clk);
        rd_reg(WDT_OFS, v);
        check("wdt runs", {31'h0, v != 32'h0}, 32'h1);
        wr_reg(ACC_OFS, 32'h21);
        cmd(3'h4, 7'h0, 1'b0, 8'h0);
        check("asleep", {30'h0, osc_enable, exec_halted}, 32'h1);
        rd_reg(STATUS_OFS, v);
        check("sleep flags", {29'h0, v[5:3]}, 32'h5);
        cmd(3'h1, 7'h0, 1'b0, 8'h0);
        repeat (300) @(posedge sys_clk);
        rd_reg(WDT_OFS, v);
        check("wdt asleep", v, 32'h0);
        rd_reg(ACC_OFS, v);
        check("acc asleep", v, 32'h21);
        wr_reg(WAKE_OFS, 32'h1);
        for (int n = 0; n < 10 && exec_halted !== 1'b0; n++)
            @(posedge sys_clk);
        check("awake", {30'h0, osc_enable, exec_halted}, 32'h2);
        // a stale prescaler would step the counter before 256 cycles
        repeat (190) @(posedge sys_clk);
        rd_reg(WDT_OFS, v);
        check("prescale clear", v, 32'h0);
        repeat (100) @(posedge sys_clk);
        rd_reg(WDT_OFS, v);
        check("wdt restarts", v, 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_rotate();
        t_sub();
        t_sleep();
        tally_and_finish();
    end

    // cut a hung handshake short
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        tally_and_finish();
    end
endmodule
